// ===== rtl/psp_pkg.sv
// Shared constants and types for the power-management serial register port
package psp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         PSP_CLK_NS        = 100;   // ref_clk period
  localparam int         PSP_SCL_PERIOD_NS = 1600;  // Serial clock made by the host end
  localparam int         PSP_QTR_CYC       = PSP_SCL_PERIOD_NS / (4 * PSP_CLK_NS);
  localparam logic [3:0] PSP_QTR_LAST      = 4'(PSP_QTR_CYC - 1);

  // ---------------------------------------------------------------
  // Protocol
  // ---------------------------------------------------------------
  localparam logic [6:0] PSP_SLAVE_ADDR = 7'h61;
  localparam logic [3:0] PSP_BIT_LAST   = 4'h7;  // Eighth data bit of a byte
  localparam logic [3:0] PSP_ACK_SLOT   = 4'h8;  // Ninth pulse
  localparam logic [3:0] PSP_ACK_END    = 4'h9;
  localparam logic [1:0] PH_ADDR        = 2'h0;
  localparam logic [1:0] PH_INDEX       = 2'h1;
  localparam logic [1:0] PH_DATA        = 2'h2;

  // ---------------------------------------------------------------
  // Device register map
  // ---------------------------------------------------------------
  localparam int         PSP_NREG     = 21;
  localparam logic [7:0] PSP_LAST_REG = 8'h14;
  typedef enum logic [7:0] {
    R_DEVICE_REVISION_ID        = 8'h00,
    R_FACTORY_PROGRAM_REVISION  = 8'h01,
    R_CONVERTER0_CONTROL_A      = 8'h02,
    R_CONVERTER0_LIMIT_SLEW     = 8'h03,
    R_CONVERTER1_CONTROL_A      = 8'h04,
    R_CONVERTER1_LIMIT_SLEW     = 8'h05,
    R_CONVERTER0_VOLTAGE        = 8'h06,
    R_CONVERTER1_VOLTAGE        = 8'h07,
    R_LINEAR0_CONTROL           = 8'h08,
    R_LINEAR1_CONTROL           = 8'h09,
    R_LINEAR0_VOLTAGE           = 8'h0a,
    R_LINEAR1_VOLTAGE           = 8'h0b,
    R_CONVERTER0_SEQUENCE_DELAY = 8'h0c,
    R_CONVERTER1_SEQUENCE_DELAY = 8'h0d,
    R_LINEAR0_SEQUENCE_DELAY    = 8'h0e,
    R_LINEAR1_SEQUENCE_DELAY    = 8'h0f,
    R_OUTPUT1_SEQUENCE_DELAY    = 8'h10,
    R_OUTPUT2_SEQUENCE_DELAY    = 8'h11,
    R_GENERAL_OUTPUT_CONTROL    = 8'h12,
    R_DEVICE_CONFIGURATION      = 8'h13,
    R_CLOCK_SYNC_CONTROL        = 8'h14
  } psp_reg_t;

  // Bits the host may write (index 20 first); read-only registers are zero
  localparam logic [20:0][7:0] PSP_WMASK = {
    8'h5f, 8'h7f, 8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f,
    8'h07, 8'h07, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'h3f, 8'h0f, 8'h00, 8'h00};
  // Bits that exist at all; factory image is cut to these at load
  localparam logic [20:0][7:0] PSP_LMASK = {
    8'h5f, 8'h7f, 8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f,
    8'h07, 8'h07, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'h3f, 8'h0f, 8'hff, 8'hc0};

  // ---------------------------------------------------------------
  // Host command registers
  // ---------------------------------------------------------------
  localparam logic [2:0] HR_CTRL   = 3'h0;
  localparam logic [2:0] HR_INDEX  = 3'h1;
  localparam logic [2:0] HR_WDATA  = 3'h2;
  localparam logic [2:0] HR_TARGET = 3'h3;
  localparam logic [2:0] HR_RDATA  = 3'h4;
  localparam logic [2:0] HR_STATUS = 3'h5;
  localparam int         HC_GO     = 0;
  localparam int         HC_READ   = 1;
  localparam int         HC_TWO    = 2;   // Second data byte in one transfer

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    DS_IDLE = 6'b000001,
    DS_RX   = 6'b000010,
    DS_ACK  = 6'b000100,
    DS_TX   = 6'b001000,
    DS_MACK = 6'b010000,
    DS_SKIP = 6'b100000
  } psp_dst_t;

  typedef enum logic [2:0] {
    SUP_OFF  = 3'b001,
    SUP_LOAD = 3'b010,
    SUP_ON   = 3'b100
  } psp_sup_t;
  localparam int SUP_ON_BIT = 2;

  typedef enum logic [8:0] {
    HS_IDLE   = 9'b000000001,
    HS_START  = 9'b000000010,
    HS_ADDR_W = 9'b000000100,
    HS_IDX    = 9'b000001000,
    HS_DATA   = 9'b000010000,
    HS_RSTART = 9'b000100000,
    HS_ADDR_R = 9'b001000000,
    HS_RDATA  = 9'b010000000,
    HS_STOP   = 9'b100000000
  } psp_hst_t;

endpackage

// ===== rtl/psp_link_if.sv
// Two-wire link between host end and device end
`timescale 1ns/1ns
interface psp_link_if;
  logic scl;       // Serial clock, host drives
  logic sda_h_o;   // Host data out
  logic sda_h_oe;  // Host drives data line
  logic sda_d_o;   // Device data out
  logic sda_d_oe;  // Device drives data line
  logic sda;       // Resolved data line

  // Open drain with pull-up: any enabled low driver wins
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

  modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// ===== rtl/psp_device.sv
// Device end: serial slave port and control register file
//
// Functional notes
// - Works at supported serial clock rates
// - Data changes only while clock low
// - Data fall with clock high starts
// - Data rise with clock high stops
// - Only the master makes start, stop
// - Bus busy from start until stop
// - Repeated start restarts address reception
// - Eight bits MSB first, then acknowledge
// - Device pulls data low on ninth pulse
// - Master leaves last read byte unacknowledged
// - Supply lockout: never drive data line (the device may keep driving it for one ref_clk cycle after dev_ready falls)
// - First byte: address plus direction bit
// - Second byte index, third byte data
// - Read needs index write, then restart
// - Answer only slave address 0x61
// - Write index advances after each byte
// - Read index never advances
// - Factory bits loaded in load state
// - Host access in standby and active
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module psp_device
  import psp_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  psp_link_if.dev               link,
  input  wire logic             supply_ok,
  input  wire logic [20:0][7:0] otp_image,
  output      logic [20:0][7:0] reg_image,
  output      logic             bus_busy,
  output      logic             dev_ready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psp_dst_t         st;
    psp_sup_t         sup;
    logic [2:0]       scl_q;  // [0],[1] synchroniser, [2] previous
    logic [2:0]       sda_q;
    logic [1:0]       pwr_q;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic [7:0]       idx;
    logic [1:0]       ph;
    logic             rw;
    logic             oe;
    logic             busy;
    logic [20:0][7:0] regs;
  } psp_dev_t;

  localparam psp_dev_t DEV_RST = '{st: DS_IDLE, sup: SUP_OFF, scl_q: 3'h7, sda_q: 3'h7, default: '0};

  psp_dev_t   r;
  psp_dev_t   n;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       ready;
  logic       in_map;
  logic [7:0] rbyte;
  logic [7:0] rd_val;
  logic [7:0] wmask;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // The second flop of the clock and data synchronisers is compared with the third. Sampling at
  // ref_clk limits the usable serial rate to about a tenth of it.
  always_comb begin
    n       = r;
    n.scl_q = {r.scl_q[1:0], link.scl};
    n.sda_q = {r.sda_q[1:0], link.sda};
    n.pwr_q = {r.pwr_q[0], supply_ok};
    rise    = r.scl_q[1] & ~r.scl_q[2];
    fall    = ~r.scl_q[1] & r.scl_q[2];
    start   = r.scl_q[1] & r.scl_q[2] & ~r.sda_q[1] & r.sda_q[2];
    stop    = r.scl_q[1] & r.scl_q[2] & r.sda_q[1] & ~r.sda_q[2];
    ready   = (r.sup == SUP_ON);
    in_map  = (r.idx <= PSP_LAST_REG);
    rbyte   = {r.sh[6:0], r.sda_q[1]};
    rd_val  = in_map ? r.regs[r.idx[4:0]] : 8'h00;
    wmask   = in_map ? PSP_WMASK[r.idx[4:0]] : 8'h00;

    // Supply tracking: registers go to zero in lockout, factory image on power-up
    case (r.sup)
      SUP_OFF: begin
        n.regs = '0;
        if (r.pwr_q[1]) begin
          n.sup = SUP_LOAD;
        end
      end
      SUP_LOAD: begin
        n.regs = otp_image & PSP_LMASK;
        n.sup  = SUP_ON;
      end
      SUP_ON: begin
        if (!r.pwr_q[1]) begin
          n.sup = SUP_OFF;
        end
      end
      default: n.sup = SUP_OFF;
    endcase

    // Byte engine; start and stop override every state
    if (start) begin
      n.st   = DS_RX;
      n.cnt  = '0;
      n.ph   = PH_ADDR;
      n.busy = 1'b1;
      n.oe   = 1'b0;
    end else if (stop) begin
      n.st   = DS_IDLE;
      n.busy = 1'b0;
      n.oe   = 1'b0;
    end else begin
      case (r.st)
        DS_RX: begin
          if (rise) begin
            n.sh  = rbyte;
            n.cnt = r.cnt + 4'h1;
            if (r.cnt == PSP_BIT_LAST) begin
              n.st = DS_ACK;
              case (r.ph)
                PH_ADDR: begin
                  if (rbyte[7:1] != PSP_SLAVE_ADDR) begin
                    n.st = DS_SKIP;
                  end
                  n.rw = rbyte[0];
                end
                PH_INDEX: n.idx = rbyte;
                default: begin
                  if (ready) begin
                    if (in_map) begin
                      n.regs[r.idx[4:0]] = (rd_val & ~wmask) | (rbyte & wmask);
                    end
                    n.idx = r.idx + 8'h01;
                  end
                end
              endcase
            end
          end
        end
        DS_ACK: begin
          if (fall && r.cnt == PSP_ACK_SLOT) begin
            n.oe  = 1'b1;
            n.cnt = PSP_ACK_END;
          end else if (fall && r.cnt == PSP_ACK_END) begin
            n.oe  = 1'b0;
            n.cnt = '0;
            if (r.ph == PH_ADDR && r.rw) begin
              n.st = DS_TX;
              n.ph = PH_DATA;
              n.sh = rd_val;
              n.oe = ~rd_val[7];
            end else begin
              n.st = DS_RX;
              n.ph = (r.ph == PH_ADDR) ? PH_INDEX : PH_DATA;
            end
          end
        end
        DS_TX: begin
          if (rise) begin
            n.cnt = r.cnt + 4'h1;
          end else if (fall) begin
            if (r.cnt == PSP_ACK_SLOT) begin
              n.oe = 1'b0;
              n.st = DS_MACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.oe = ~r.sh[6];
            end
          end
        end
        DS_MACK: begin
          // Index held, so every byte of a read is the same register
          if (rise) begin
            if (r.sda_q[1]) begin
              n.st = DS_SKIP;
            end else begin
              n.cnt = PSP_ACK_END;
            end
          end else if (fall && r.cnt == PSP_ACK_END) begin
            n.st  = DS_TX;
            n.cnt = '0;
            n.sh  = rd_val;
            n.oe  = ~rd_val[7];
          end
        end
        default: n.oe = 1'b0;  // Idle or skipping: line released
      endcase
    end

    // Lockout wins over every driver in the engine
    if (!ready) begin
      n.oe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // Device only ever pulls low
  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = r.oe;
  assign reg_image     = r.regs;
  assign bus_busy      = r.busy;
  assign dev_ready     = r.sup[SUP_ON_BIT];

endmodule

// ===== rtl/psp_host.sv
// Host end: two-wire master driven from a small command register port
`timescale 1ns/1ns
module psp_host
  import psp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  psp_link_if.host        link,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output      logic [7:0] rdata
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psp_hst_t   st;
    logic [1:0] ph;    // Quarter of the serial clock period
    logic [3:0] tq;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] sda_q;
    logic       scl;
    logic       oe;
    logic       rd_op;
    logic       more;  // Second data byte still to come
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [6:0] tgt;
    logic [7:0] rdat;
    logic       busy;
    logic       nack;
    logic       done;
    logic [7:0] rdata;
  } psp_host_st_t;

  localparam psp_host_st_t HOST_RST = '{st: HS_IDLE, scl: 1'b1, tgt: PSP_SLAVE_ADDR, default: '0};

  psp_host_st_t r;
  psp_host_st_t n;
  logic         tick;
  logic         rx_byte;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n       = r;
    n.sda_q = {r.sda_q[0], link.sda};
    tick    = (r.tq == PSP_QTR_LAST);
    rx_byte = (r.st == HS_RDATA);
    n.tq    = (tick || !r.busy) ? 4'h0 : r.tq + 4'h1;

    // Bit engine: quarter 0 sets data with clock low, 1 raises, 2 samples, 3 lowers
    if (r.busy && tick) begin
      n.ph = r.ph + 2'h1;
      case (r.st)
        HS_START, HS_RSTART: begin
          case (r.ph)
            2'h0: n.oe  = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.oe  = 1'b1;
            default: begin
              n.scl  = 1'b0;
              n.bitn = '0;
              n.sh   = {r.tgt, r.st == HS_RSTART};
              n.st   = (r.st == HS_START) ? HS_ADDR_W : HS_ADDR_R;
            end
          endcase
        end
        HS_ADDR_W, HS_IDX, HS_DATA, HS_ADDR_R, HS_RDATA: begin
          case (r.ph)
            // Host acknowledges a read byte only when another one is wanted
            2'h0: n.oe  = rx_byte ? ((r.bitn == PSP_ACK_SLOT) && r.more)
                                  : ((r.bitn != PSP_ACK_SLOT) && !r.sh[7]);
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitn != PSP_ACK_SLOT) begin
                n.sh = {r.sh[6:0], r.sda_q[1]};
              end else if (!rx_byte && r.sda_q[1]) begin
                n.nack = 1'b1;
              end
            end
            default: begin
              n.scl  = 1'b0;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == PSP_ACK_SLOT) begin
                n.bitn = '0;
                case (r.st)
                  HS_ADDR_W: begin
                    n.st = HS_IDX;
                    n.sh = r.idx;
                  end
                  HS_IDX: begin
                    n.st = r.rd_op ? HS_RSTART : HS_DATA;
                    n.sh = r.wdat;
                  end
                  HS_ADDR_R: n.st = HS_RDATA;
                  HS_DATA: begin
                    // Same byte again; the device puts it one register up
                    n.st   = r.more ? HS_DATA : HS_STOP;
                    n.more = 1'b0;
                    n.sh   = r.wdat;
                  end
                  HS_RDATA: begin
                    n.st   = r.more ? HS_RDATA : HS_STOP;
                    n.more = 1'b0;
                    n.rdat = r.sh;
                  end
                  default: n.st = HS_STOP;
                endcase
                if (r.nack) begin
                  n.st = HS_STOP;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          case (r.ph)
            2'h0: n.oe  = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.oe  = 1'b0;
            default: begin
              n.st   = HS_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
        default: n.st = HS_IDLE;
      endcase
    end

    // Command port; a go while busy is dropped
    if (wr) begin
      case (addr)
        HR_CTRL: begin
          if (wdata[HC_GO] && !r.busy) begin
            n.busy  = 1'b1;
            n.rd_op = wdata[HC_READ];
            n.more  = wdata[HC_TWO];
            n.nack  = 1'b0;
            n.done  = 1'b0;
            n.st    = HS_START;
            n.ph    = 2'h0;
            n.tq    = 4'h0;
          end
        end
        HR_INDEX:  n.idx  = wdata;
        HR_WDATA:  n.wdat = wdata;
        HR_TARGET: n.tgt  = wdata[6:0];
        default:   n.idx  = r.idx;
      endcase
    end

    // Read data valid the cycle after the strobe only
    n.rdata = 8'h00;
    if (rd) begin
      case (addr)
        HR_CTRL:   n.rdata = {6'h00, r.rd_op, r.busy};
        HR_INDEX:  n.rdata = r.idx;
        HR_WDATA:  n.rdata = r.wdat;
        HR_TARGET: n.rdata = {1'b0, r.tgt};
        HR_RDATA:  n.rdata = r.rdat;
        HR_STATUS: n.rdata = {5'h00, r.done, r.nack, r.busy};
        default:   n.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  assign link.scl      = r.scl;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = r.oe;
  assign rdata         = r.rdata;

endmodule

// ===== test/psp_link_sva.sv
// Protocol checker for the two-wire link between host end and device end
`timescale 1ns/1ns
module psp_link_sva
  import psp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_d_oe,
  input wire logic sda,
  input wire logic bus_busy,
  input wire logic dev_ready
);
  // ----------
  // Helper logic
  // ----------
  logic       scl_q;
  logic       sda_q;
  logic       dir;
  logic       foreign;
  logic [3:0] cnt;
  logic [1:0] byte_no;
  logic [7:0] sh;
  logic [7:0] st_hist;
  logic       rise;
  logic       start_ev;
  logic       stop_ev;
  logic       miss;

  // Line events as seen on the raw wires
  assign rise     = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign miss     = rise && cnt == PSP_ACK_SLOT && byte_no == 2'h0 && sh[7:1] != PSP_SLAVE_ADDR;

  // Pulse position restarts at every start, so a repeated start re-arms it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      dir     <= 1'b0;
      foreign <= 1'b0;
      cnt     <= 4'h0;
      byte_no <= 2'h0;
      sh      <= 8'h00;
      st_hist <= 8'h00;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      st_hist <= {st_hist[6:0], start_ev};
      if (start_ev)
        foreign <= 1'b0;
      else if (miss)
        foreign <= 1'b1;
      if (start_ev || stop_ev) begin
        cnt     <= 4'h0;
        byte_no <= 2'h0;
      end else if (rise) begin
        cnt <= (cnt == PSP_ACK_SLOT) ? 4'h0 : cnt + 4'h1;
        if (cnt == PSP_ACK_SLOT && byte_no != 2'h3)
          byte_no <= byte_no + 2'h1;
        if (cnt != PSP_ACK_SLOT)
          sh <= {sh[6:0], sda};
        if (cnt == PSP_BIT_LAST && byte_no == 2'h0)
          dir <= sda;
      end
    end
  end

  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  chk_data_stable: assert property (scl && scl_q |-> $stable(sda_d_oe))
    else $error("device data line moved while clock high");
  chk_start_busy: assert property (dev_ready && start_ev |-> ##[1:6] bus_busy)
    else $error("start not followed by busy");
  chk_stop_free: assert property (stop_ev |-> ##[1:6] !bus_busy)
    else $error("stop not followed by free bus");
  chk_busy_cause: assert property ($rose(bus_busy) |-> st_hist != 8'h00)
    else $error("busy rose without a start");
  chk_lockout_quiet: assert property (!dev_ready && !$past(dev_ready) |-> !sda_d_oe)
    else $error("device drove data line while not ready");
  chk_pulse_slot: assert property (rise && sda_d_oe |->
    ((dir && byte_no != 2'h0) ? cnt != PSP_ACK_SLOT : cnt == PSP_ACK_SLOT))
    else $error("device drove data line in wrong pulse");
  chk_ack_match: assert property (rise && cnt == PSP_ACK_SLOT && byte_no == 2'h0 &&
    dev_ready && sh[7:1] == PSP_SLAVE_ADDR |-> sda_d_oe)
    else $error("own address not acknowledged");
  chk_foreign_quiet: assert property (foreign || miss |-> !sda_d_oe)
    else $error("device answered a foreign address");

  // Main scenarios reached
  cov_restart: cover property (bus_busy && start_ev);
  cov_ack: cover property (rise && cnt == PSP_ACK_SLOT && sda_d_oe);
  cov_read_bit: cover property (rise && dir && byte_no != 2'h0 && sda_d_oe);
endmodule

// ===== test/pmic_serial_register_port_tb.sv
// Self-checking bench joining host end and device end over the link
`timescale 1ns/1ns
module pmic_serial_register_port_tb
  import psp_pkg::*;
;
  logic             ref_clk;
  logic             arst_n;
  logic             supply_ok;
  logic [20:0][7:0] otp_image;
  logic [20:0][7:0] reg_image;
  logic             bus_busy;
  logic             dev_ready;
  logic [2:0]       addr;
  logic [7:0]       wdata;
  logic             wr;
  logic             rd;
  logic [7:0]       rdata;
  logic [7:0]       st;
  logic [7:0]       got;
  logic             two_bytes;
  int               num_errors;
  int               comparisons;
  // Rows: index, written byte, byte expected back (reserved bits read zero)
  logic [23:0]      rows [12] = '{24'h00ff40, 24'h01ff5a, 24'h02ff0f, 24'h03ff3f, 24'h08ff07, 24'h0aa505,
                                  24'h06a5a5, 24'h12ff77, 24'h13ff7f, 24'h14ff5f, 24'h0c0000, 24'h15aa00};
  logic [6:0]       bad [3] = '{7'h60, 7'h21, 7'h71};

  // ----------
  // Ends, link and checker
  // ----------
  psp_link_if link ();
  psp_host psp_host_i (.ref_clk(ref_clk), .arst_n(arst_n), .link(link), .addr(addr), .wdata(wdata),
                       .wr(wr), .rd(rd), .rdata(rdata));
  psp_device psp_device_i (.ref_clk(ref_clk), .arst_n(arst_n), .link(link), .supply_ok(supply_ok),
                           .otp_image(otp_image), .reg_image(reg_image), .bus_busy(bus_busy),
                           .dev_ready(dev_ready));
  psp_link_sva psp_link_sva_i (.ref_clk(ref_clk), .arst_n(arst_n), .scl(link.scl), .sda_d_oe(link.sda_d_oe),
                               .sda(link.sda), .bus_busy(bus_busy), .dev_ready(dev_ready));

  // 10 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic tally_and_finish;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle strobes; the next call waits an edge so a strobe is never set twice at once
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  // Full transfer by the host end; leaves done, nack, busy in st
  task automatic xfer(input logic rd_op, input logic [7:0] idx, input logic [7:0] d);
    int n;
    reg_wr(HR_INDEX, idx);
    reg_wr(HR_WDATA, d);
    reg_wr(HR_CTRL, {5'h00, two_bytes, rd_op, 1'b1});
    n = 0;
    do begin
      reg_rd(HR_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 1000);
    if (st[0] !== 1'b0) begin
      num_errors++;
      $display("[FAIL] busy expected 0 seen 1");
      tally_and_finish();
    end
    st = {5'h00, st[2:0]};
  endtask

  task automatic wait_ready(input logic want);
    for (int n = 0; n < 50 && dev_ready !== want; n++)
      @(negedge ref_clk);
    chk("ready", {7'h00, want}, {7'h00, dev_ready});
    if (dev_ready !== want)
      tally_and_finish();
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    arst_n      = 1'b0;
    supply_ok   = 1'b0;
    otp_image   = {21{8'h5a}};
    addr        = 3'h0;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    two_bytes   = 1'b0;
    num_errors  = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    chk("idle lines", 8'h03, {6'h00, link.scl, link.sda});
    // Supply below lockout: no acknowledge, nothing stored
    xfer(1'b0, 8'h02, 8'hff);
    chk("lockout status", 8'h06, st);
    chk("lockout reg", 8'h00, reg_image[2]);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_ready(1'b1);
    for (int i = 0; i < PSP_NREG; i++)
      chk("loaded", 8'h5a & PSP_LMASK[i], reg_image[i]);
    // Table: write, then index write plus repeated start and one-byte read
    foreach (rows[k]) begin
      xfer(1'b0, rows[k][23:16], rows[k][15:8]);
      chk("write status", 8'h04, st);
      if (rows[k][23:16] <= PSP_LAST_REG)
        chk("stored", rows[k][7:0], reg_image[rows[k][23:16]]);
      xfer(1'b1, rows[k][23:16], 8'h00);
      chk("read status", 8'h04, st);
      reg_rd(HR_RDATA, got);
      chk("read data", rows[k][7:0], got);
    end
    // Two data bytes: index advances on write, holds on read
    two_bytes = 1'b1;
    xfer(1'b0, 8'h0c, 8'h3c);
    chk("pair write status", 8'h04, st);
    chk("pair first", 8'h3c, reg_image[12]);
    chk("pair second", 8'h3c, reg_image[13]);
    xfer(1'b1, 8'h06, 8'h00);
    chk("pair read status", 8'h04, st);
    two_bytes = 1'b0;
    reg_rd(HR_RDATA, got);
    chk("held read", 8'ha5, got);
    // Foreign addresses differing in low, high and middle bits
    foreach (bad[k]) begin
      reg_wr(HR_TARGET, {1'b0, bad[k]});
      xfer(1'b0, 8'h06, 8'h00);
      chk("foreign status", 8'h06, st);
      chk("foreign reg", 8'ha5, reg_image[6]);
    end
    reg_wr(HR_TARGET, {1'b0, PSP_SLAVE_ADDR});
    // Supply drop mid-run clears registers and silences the port
    supply_ok <= 1'b0;
    wait_ready(1'b0);
    @(negedge ref_clk);
    chk("dropped reg", 8'h00, reg_image[6]);
    xfer(1'b1, 8'h06, 8'h00);
    chk("dropped status", 8'h06, st);
    chk("idle lines", 8'h03, {6'h00, link.scl, link.sda});
    tally_and_finish();
  end
endmodule
